// File: rtl/hpsc_pkg.sv
// Constants for the product string length and device configuration 3 registers.
package hpsc_pkg;

    localparam int          HPSC_LEN_W          = 7;
    localparam int          HPSC_ADDR_W         = 6;
    localparam logic [7:0]  HPSC_OFS_PROD_LEN   = 8'h24;
    localparam logic [7:0]  HPSC_OFS_CFG3       = 8'h25;
    localparam logic [6:0]  HPSC_PROD_LEN_RST   = 7'h00;
    localparam logic [6:0]  HPSC_PROD_LEN_MAX   = 7'h40;
    localparam logic [3:0]  HPSC_CFG3_RST       = 4'h0;
    localparam int          HPSC_BIT_LEGACY     = 4;
    localparam int          HPSC_BIT_SLOW_RATE  = 2;
    localparam int          HPSC_BIT_VEND_EXCL  = 1;
    localparam int          HPSC_BIT_FULL_AUTO  = 0;
    localparam logic [7:0]  HPSC_PROD_STR_INDEX = 8'h03;

    typedef enum logic [1:0]
    {
        HPSC_IDLE = 2'b01,
        HPSC_SEND = 2'b10
    } hpsc_state_e;

endpackage

// File: rtl/hpsc_streamer.sv
// Walks the product string data registers when string index 3 is requested.
`timescale 1ns/1ps

module hpsc_streamer
    import hpsc_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   sys_rst_i,
    input  wire logic [HPSC_LEN_W-1:0]  length_i,
    input  wire logic                   str_req_i,
    input  wire logic [7:0]             str_index_i,
    output logic      [HPSC_ADDR_W-1:0] str_byte_addr_o,
    output logic                        str_byte_valid_o,
    output logic                        str_byte_last_o,
    output logic                        str_none_o
);

    hpsc_state_e            state;
    hpsc_state_e            next_state;
    logic [HPSC_LEN_W-1:0]  len_q;
    logic [HPSC_LEN_W-1:0]  next_len_q;
    logic [HPSC_ADDR_W-1:0] next_addr;
    logic                   next_valid;
    logic                   next_last;
    logic                   next_none;
    logic                   start;
    logic [HPSC_LEN_W-1:0]  addr_plus2;

    assign start      = str_req_i && (str_index_i == HPSC_PROD_STR_INDEX);
    assign addr_plus2 = {1'b0, str_byte_addr_o} + 7'h02;

    ////////////////////////////////////////////////////////////////////////////
    // Requests arriving while a string is in flight are ignored.
    always_comb
    begin
        next_state = state;
        next_len_q = len_q;
        next_addr  = str_byte_addr_o;
        next_valid = 1'b0;
        next_last  = 1'b0;
        next_none  = 1'b0;
        unique case (state)
            HPSC_IDLE:
            begin
                if (start && (length_i != '0))
                begin
                    next_state = HPSC_SEND;
                    next_len_q = length_i;
                    next_addr  = '0;
                    next_valid = 1'b1;
                    next_last  = (length_i == 7'h01);
                end
                else if (start)
                begin
                    next_none = 1'b1;
                end
            end
            HPSC_SEND:
            begin
                if (str_byte_last_o)
                begin
                    next_state = HPSC_IDLE;
                end
                else
                begin
                    next_addr  = str_byte_addr_o + 6'h01;
                    next_valid = 1'b1;
                    next_last  = (addr_plus2 == len_q);
                end
            end
            default:
            begin
                next_state = HPSC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            state            <= HPSC_IDLE;
            len_q            <= HPSC_PROD_LEN_RST;
            str_byte_addr_o  <= '0;
            str_byte_valid_o <= 1'b0;
            str_byte_last_o  <= 1'b0;
            str_none_o       <= 1'b0;
        end
        else
        begin
            state            <= next_state;
            len_q            <= next_len_q;
            str_byte_addr_o  <= next_addr;
            str_byte_valid_o <= next_valid;
            str_byte_last_o  <= next_last;
            str_none_o       <= next_none;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    a_stream_first_byte: assert property (
        (state == HPSC_IDLE) && start && (length_i != '0)
        |=> str_byte_valid_o && (str_byte_addr_o == '0))
        else $error("string stream did not start at byte zero");

    a_last_byte_count: assert property (
        str_byte_last_o |-> ({1'b0, str_byte_addr_o} + 7'h01 == len_q))
        else $error("last string byte does not match length");

    a_empty_no_string: assert property (
        (state == HPSC_IDLE) && start && (length_i == '0)
        |=> str_none_o && !str_byte_valid_o)
        else $error("zero length did not report an absent string");

    c_stream_done: cover property (str_byte_valid_o && str_byte_last_o);
    c_stream_none: cover property (str_none_o);

endmodule

// File: rtl/hpsc_regs.sv
// Product string length and device configuration 3 registers of the hub.
`timescale 1ns/1ps

// Operation
// - Unused upper bits of both registers read zero; writes to them are ignored.
// - The seven-bit product length field counts the product string in bytes.
// - Length resets to zero; zero means no product string is offered.
// - Product length never exceeds sixty-four bytes, whatever a source loads.
// - Length is writable only while the custom strings option is one.
// - Non-zero length: string index 3 returns that many product string bytes.
// - Four configuration bits are writable; reads return written value OR eFuse bit.
module hpsc_regs
    import hpsc_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   sys_rst_i,
    input  wire logic                   custom_text_enable_i,
    input  wire logic                   cfg_wr_i,
    input  wire logic                   cfg_rd_i,
    input  wire logic [7:0]             cfg_addr_i,
    input  wire logic [7:0]             cfg_wdata_i,
    output logic      [7:0]             cfg_rdata_o,
    output logic                        cfg_rvalid_o,
    input  wire logic                   efuse_legacy_speed_only_i,
    input  wire logic                   efuse_slow_two_wire_rate_i,
    input  wire logic                   efuse_vendor_charge_exclude_i,
    input  wire logic                   efuse_full_auto_divider_charge_i,
    output logic                        legacy_speed_only_o,
    output logic                        slow_two_wire_rate_o,
    output logic                        vendor_charge_exclude_o,
    output logic                        full_auto_divider_charge_o,
    output logic                        ss_5g_advertise_o,
    output logic                        ss_hub_enable_o,
    output logic                        product_text_present_o,
    input  wire logic                   str_req_i,
    input  wire logic [7:0]             str_index_i,
    output logic      [HPSC_ADDR_W-1:0] str_byte_addr_o,
    output logic                        str_byte_valid_o,
    output logic                        str_byte_last_o,
    output logic                        str_none_o
);

    logic [HPSC_LEN_W-1:0] product_text_length;
    logic [HPSC_LEN_W-1:0] next_product_text_length;
    logic [3:0]            cfg_bits;
    logic [3:0]            next_cfg_bits;
    logic [3:0]            efuse_bits;
    logic [3:0]            eff_bits;
    logic [7:0]            cfg3_view;
    logic [7:0]            next_rdata;
    logic                  next_present;

    // Written bits are packed legacy, slow rate, vendor exclusion, full auto.
    assign efuse_bits = {efuse_legacy_speed_only_i, efuse_slow_two_wire_rate_i,
                         efuse_vendor_charge_exclude_i, efuse_full_auto_divider_charge_i};
    assign eff_bits   = cfg_bits | efuse_bits;

    always_comb
    begin
        cfg3_view                     = 8'h00;
        cfg3_view[HPSC_BIT_LEGACY]    = eff_bits[3];
        cfg3_view[HPSC_BIT_SLOW_RATE] = eff_bits[2];
        cfg3_view[HPSC_BIT_VEND_EXCL] = eff_bits[1];
        cfg3_view[HPSC_BIT_FULL_AUTO] = eff_bits[0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes from the EEPROM loader or the SMBus host.
    always_comb
    begin
        next_product_text_length = product_text_length;
        next_cfg_bits            = cfg_bits;
        if (cfg_wr_i && (cfg_addr_i == HPSC_OFS_PROD_LEN) && custom_text_enable_i)
        begin
            // Over-long lengths are clamped rather than dropped.
            if (cfg_wdata_i[6:0] > HPSC_PROD_LEN_MAX)
            begin
                next_product_text_length = HPSC_PROD_LEN_MAX;
            end
            else
            begin
                next_product_text_length = cfg_wdata_i[6:0];
            end
        end
        if (cfg_wr_i && (cfg_addr_i == HPSC_OFS_CFG3))
        begin
            next_cfg_bits = {cfg_wdata_i[HPSC_BIT_LEGACY], cfg_wdata_i[HPSC_BIT_SLOW_RATE],
                             cfg_wdata_i[HPSC_BIT_VEND_EXCL], cfg_wdata_i[HPSC_BIT_FULL_AUTO]};
        end
        next_present = (next_product_text_length != '0);
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            product_text_length    <= HPSC_PROD_LEN_RST;
            cfg_bits               <= HPSC_CFG3_RST;
            product_text_present_o <= 1'b0;
        end
        else
        begin
            product_text_length    <= next_product_text_length;
            cfg_bits               <= next_cfg_bits;
            product_text_present_o <= next_present;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port and effective configuration outputs.
    always_comb
    begin
        next_rdata = 8'h00;
        if (cfg_rd_i && (cfg_addr_i == HPSC_OFS_PROD_LEN))
        begin
            next_rdata = {1'b0, product_text_length};
        end
        else if (cfg_rd_i && (cfg_addr_i == HPSC_OFS_CFG3))
        begin
            next_rdata = cfg3_view;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            cfg_rdata_o                <= 8'h00;
            cfg_rvalid_o               <= 1'b0;
            legacy_speed_only_o        <= 1'b0;
            slow_two_wire_rate_o       <= 1'b0;
            vendor_charge_exclude_o    <= 1'b0;
            full_auto_divider_charge_o <= 1'b0;
            ss_5g_advertise_o          <= 1'b0;
            ss_hub_enable_o            <= 1'b0;
        end
        else
        begin
            cfg_rdata_o                <= next_rdata;
            cfg_rvalid_o               <= cfg_rd_i;
            legacy_speed_only_o        <= eff_bits[3];
            slow_two_wire_rate_o       <= eff_bits[2];
            vendor_charge_exclude_o    <= eff_bits[1];
            full_auto_divider_charge_o <= eff_bits[0];
            ss_5g_advertise_o          <= !eff_bits[3];
            ss_hub_enable_o            <= !eff_bits[3];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    hpsc_streamer hpsc_streamer_inst
    (
        .clk_i            (clk_i),
        .sys_rst_i        (sys_rst_i),
        .length_i         (product_text_length),
        .str_req_i        (str_req_i),
        .str_index_i      (str_index_i),
        .str_byte_addr_o  (str_byte_addr_o),
        .str_byte_valid_o (str_byte_valid_o),
        .str_byte_last_o  (str_byte_last_o),
        .str_none_o       (str_none_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    a_rsvd_read_zero: assert property (
        cfg_rvalid_o && ($past(cfg_addr_i) == HPSC_OFS_CFG3) |-> (cfg_rdata_o[7:5] == 3'h0)
        && (cfg_rdata_o[3] == 1'b0))
        else $error("reserved configuration bits read non-zero");

    a_len_read_back: assert property (
        cfg_rvalid_o && ($past(cfg_addr_i) == HPSC_OFS_PROD_LEN)
        |-> (cfg_rdata_o == {1'b0, $past(product_text_length)}))
        else $error("product length read back wrong");

    a_present_flag: assert property (
        product_text_present_o == (product_text_length != '0))
        else $error("product string presence disagrees with length");

    a_len_max_bound: assert property (
        product_text_length <= HPSC_PROD_LEN_MAX)
        else $error("product length above sixty-four");

    a_len_locked: assert property (
        !custom_text_enable_i |=> $stable(product_text_length))
        else $error("product length changed while locked");

    a_cfg_or_efuse: assert property (
        efuse_legacy_speed_only_i |=> legacy_speed_only_o)
        else $error("legacy speed bit ignores eFuse");

    a_ss_disable: assert property (
        legacy_speed_only_o |-> !ss_5g_advertise_o && !ss_hub_enable_o)
        else $error("SuperSpeed left enabled in legacy mode");

    a_ss_enabled: assert property (
        !$past(sys_rst_i) && !legacy_speed_only_o |-> ss_5g_advertise_o && ss_hub_enable_o)
        else $error("SuperSpeed withheld outside legacy mode");

    a_eff_follow: assert property (
        !$past(sys_rst_i) |-> ({legacy_speed_only_o, slow_two_wire_rate_o,
        vendor_charge_exclude_o, full_auto_divider_charge_o} == $past(cfg_bits | efuse_bits)))
        else $error("effective configuration bits do not follow written OR eFuse");

    a_len_write_lands: assert property (
        cfg_wr_i && custom_text_enable_i && (cfg_addr_i == HPSC_OFS_PROD_LEN)
        && (cfg_wdata_i[6:0] <= HPSC_PROD_LEN_MAX)
        |=> (product_text_length == $past(cfg_wdata_i[6:0])))
        else $error("permitted product length write did not land");

    a_len_clamp: assert property (
        cfg_wr_i && custom_text_enable_i && (cfg_addr_i == HPSC_OFS_PROD_LEN)
        && (cfg_wdata_i[6:0] > HPSC_PROD_LEN_MAX)
        |=> (product_text_length == HPSC_PROD_LEN_MAX))
        else $error("over-long product length was not clamped");

    a_unmapped_zero: assert property (
        cfg_rvalid_o && ($past(cfg_addr_i) != HPSC_OFS_PROD_LEN)
        && ($past(cfg_addr_i) != HPSC_OFS_CFG3) |-> (cfg_rdata_o == 8'h00))
        else $error("unmapped offset read non-zero");

    c_len_written: cover property (custom_text_enable_i && cfg_wr_i
        && (cfg_addr_i == HPSC_OFS_PROD_LEN) ##1 product_text_length != '0);
    c_cfg3_read: cover property (cfg_rvalid_o && (cfg_rdata_o[HPSC_BIT_LEGACY] == 1'b1));

endmodule

// File: test/hpsc_eeprom_model.sv
// Serial EEPROM model that loads a length and a configuration byte on request.
`timescale 1ns/1ps

module hpsc_eeprom_model
    import hpsc_pkg::*;
#(
    parameter logic [6:0] LOAD_LEN = 7'h05,
    parameter logic [7:0] LOAD_CFG = 8'h04
)
(
    input  wire logic       clk_i,
    input  wire logic       start_i,
    output logic            wr_o,
    output logic      [7:0] addr_o,
    output logic      [7:0] wdata_o
);
    initial
    begin
        wr_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end

    // Loads the length first, then the configuration byte, one strobe each.
    always @(negedge clk_i)
    begin
        if (start_i && !wr_o)
        begin
            wr_o <= 1'b1;
            addr_o <= HPSC_OFS_PROD_LEN;
            wdata_o <= {1'b0, LOAD_LEN};
        end
        else if (wr_o && addr_o == HPSC_OFS_PROD_LEN)
        begin
            addr_o <= HPSC_OFS_CFG3;
            wdata_o <= LOAD_CFG;
        end
        else
        begin
            // Released lines invert every cycle, so they show the last value on alternate cycles.
            wr_o <= 1'b0;
            addr_o <= ~addr_o;
            wdata_o <= ~wdata_o;
        end
    end
endmodule

// File: test/hub_product_string_and_config3_regs_bench.sv
// Self-checking bench for the product length and configuration 3 registers.
`timescale 1ns/1ps

module hub_product_string_and_config3_regs_bench;
    import hpsc_pkg::*;

    logic       clk_i, sys_rst_i, custom, tb_wr, rd, start, req;
    logic [7:0] tb_addr, wdata, idx, rdata;
    logic [3:0] efuse;
    wire  [3:0] eff;
    logic [5:0] saddr;
    logic       rvalid, ss5g, sshub, present, svalid, slast, snone, ee_wr;
    logic [7:0] ee_addr, ee_wdata;
    int         fail_count = 0;
    int         comparisons = 0;

    hpsc_eeprom_model hpsc_eeprom_model_inst (.clk_i(clk_i), .start_i(start), .wr_o(ee_wr),
        .addr_o(ee_addr), .wdata_o(ee_wdata));

    hpsc_regs hpsc_regs_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .custom_text_enable_i(custom), .cfg_wr_i(tb_wr | ee_wr), .cfg_rd_i(rd),
        .cfg_addr_i(ee_wr ? ee_addr : tb_addr), .cfg_wdata_i(ee_wr ? ee_wdata : wdata),
        .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid),
        .efuse_legacy_speed_only_i(efuse[3]), .efuse_slow_two_wire_rate_i(efuse[2]),
        .efuse_vendor_charge_exclude_i(efuse[1]),
        .efuse_full_auto_divider_charge_i(efuse[0]),
        .legacy_speed_only_o(eff[3]), .slow_two_wire_rate_o(eff[2]),
        .vendor_charge_exclude_o(eff[1]), .full_auto_divider_charge_o(eff[0]),
        .ss_5g_advertise_o(ss5g), .ss_hub_enable_o(sshub), .product_text_present_o(present),
        .str_req_i(req), .str_index_i(idx), .str_byte_addr_o(saddr),
        .str_byte_valid_o(svalid), .str_byte_last_o(slast), .str_none_o(snone));

    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Ends two cycles after the strobe so the effective outputs have landed.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        tb_wr = 1'b1;
        tb_addr = a;
        wdata = d;
        @(negedge clk_i);
        tb_wr = 1'b0;
        @(negedge clk_i);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_i);
        rd = 1'b1;
        tb_addr = a;
        @(negedge clk_i);
        rd = 1'b0;
        chk("rvalid", 8'h01, {7'h00, rvalid});
        chk("rdata", exp, rdata);
    endtask

    task automatic stream(input logic [7:0] index, input int n, input logic none);
        @(negedge clk_i);
        req = 1'b1;
        idx = index;
        @(negedge clk_i);
        req = 1'b0;
        if (n == 0)
            chk("none", {6'h00, none, 1'b0}, {6'h00, snone, svalid});
        for (int i = 0; i < n; i++)
        begin
            chk("byte", {1'b1, i == n - 1, i[5:0]}, {svalid, slast, saddr});
            @(negedge clk_i);
        end
        chk("idle", 8'h00, {7'h00, svalid});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #20000;
        fail_count++;
        give_verdict();
    end

    initial
    begin
        {sys_rst_i, custom, tb_wr, rd, start, req} = 6'h20;
        {tb_addr, wdata, idx, efuse} = '0;
        repeat (2) @(negedge clk_i);
        sys_rst_i = 1'b0;
        @(negedge clk_i);
        chk("ss", 8'h03, {6'h00, ss5g, sshub});
        chk("present", 8'h00, {7'h00, present});
        rd_chk(HPSC_OFS_PROD_LEN, 8'h00);
        rd_chk(HPSC_OFS_CFG3, 8'h00);
        stream(HPSC_PROD_STR_INDEX, 0, 1'b1);
        wr(HPSC_OFS_PROD_LEN, 8'h05);
        rd_chk(HPSC_OFS_PROD_LEN, 8'h00);
        custom = 1'b1;
        start <= 1'b1;
        @(negedge clk_i);
        start <= 1'b0;
        repeat (4) @(negedge clk_i);
        rd_chk(HPSC_OFS_PROD_LEN, 8'h05);
        rd_chk(HPSC_OFS_CFG3, 8'h04);
        chk("present", 8'h01, {7'h00, present});
        wr(HPSC_OFS_PROD_LEN, 8'hff);
        rd_chk(HPSC_OFS_PROD_LEN, 8'h40);
        wr(HPSC_OFS_PROD_LEN, 8'h02);
        rd_chk(HPSC_OFS_PROD_LEN, 8'h02);
        stream(8'h04, 0, 1'b0);
        stream(HPSC_PROD_STR_INDEX, 2, 1'b0);
        wr(HPSC_OFS_CFG3, 8'hff);
        rd_chk(HPSC_OFS_CFG3, 8'h17);
        chk("eff", 8'h0f, {4'h0, eff});
        chk("ss", 8'h00, {6'h00, ss5g, sshub});
        rd_chk(8'h26, 8'h00);
        wr(HPSC_OFS_CFG3, 8'h00);
        for (int b = 0; b < 4; b++)
        begin
            efuse = 4'h1 << b;
            repeat (2) @(negedge clk_i);
            rd_chk(HPSC_OFS_CFG3, {3'h0, efuse[3], 1'b0, efuse[2:0]});
            chk("eff", {4'h0, efuse}, {4'h0, eff});
            chk("ss", {6'h00, {2{~efuse[3]}}}, {6'h00, ss5g, sshub});
        end
        sys_rst_i = 1'b1;
        @(negedge clk_i);
        sys_rst_i = 1'b0;
        rd_chk(HPSC_OFS_PROD_LEN, 8'h00);
        chk("present", 8'h00, {7'h00, present});
        chk("eff", 8'h08, {4'h0, eff});
        chk("ss", 8'h00, {6'h00, ss5g, sshub});
        give_verdict();
    end
endmodule
